// ### pkg/sras_defs.svh
`ifndef SRAS_DEFS_SVH
`define SRAS_DEFS_SVH

// Command word layout
`define SRAS_WORD_BITS    16
`define SRAS_ADDR_BITS    10
`define SRAS_EN_MSB       15
`define SRAS_EN_LSB       11
`define SRAS_EN_PATTERN   5'h1C
`define SRAS_RW_BIT       10
`define SRAS_ADDR_MSB     9
`define SRAS_RW_READ      1'h1

// Pointer limit and bit counting
`define SRAS_ADDR_MAX     1023
`define SRAS_CNT_BITS     4
`define SRAS_CNT_LAST     4'hF
`define SRAS_CNT_ONE      4'h1

// Synchroniser reset image: sclk low, chip select high, data low
`define SRAS_SYNC_BITS    3
`define SRAS_SYNC_RST     3'h2

`endif

// ### pkg/sras_pkg.sv
`include "sras_defs.svh"

package sras_pkg;

    typedef enum logic [2:0] {
        SRAS_IDLE,
        SRAS_CMD,
        SRAS_WRITE,
        SRAS_READ,
        SRAS_IGNORE
    } sras_state_t;

    typedef struct packed {
        logic [`SRAS_ADDR_BITS-1:0] addr;
        logic [`SRAS_WORD_BITS-1:0] data;
    } sras_wr_t;

endpackage : sras_pkg

// ### design/sras_sync.sv
`timescale 1ns/1ps

module sras_sync #(
    parameter int                 WIDTH     = 1,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : sras_sync

// ### design/sras_slave.sv
// Function
// - Command bits 15..11 must be 11100 or transaction is refused.
// - Command bit 10: one reads, zero writes.
// - Command bits 9..0 give the starting register address.
// - Input sampled on rising sclk, output changed on falling sclk.
// - Write: data words follow; first goes to the commanded address.
// - Each further write word goes to the next register.
// - Writes stop at chip select high or pointer maximum; no wrap, excess dropped.
// - Works whether sclk idles high or low between writes.
// - First read bit driven on first falling edge after command.
// - Read words keep streaming while the master clocks.
// - Chip select high ends a read and stops output.
// - At pointer maximum, reads repeat the last register.
`timescale 1ns/1ps
`include "sras_defs.svh"

module sras_slave #(
    parameter int unsigned MAX_ADDR = `SRAS_ADDR_MAX
) (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    // Serial pins
    input  wire logic                        spi_sclk,
    input  wire logic                        spi_cs_n,
    input  wire logic                        spi_sdi,
    output logic                             spi_sdo,
    output logic                             spi_sdo_oe,
    // Register file write port
    output logic                             reg_wr,
    output sras_pkg::sras_wr_t               reg_wr_req,
    // Register file read port
    output logic                             reg_rd,
    output logic [`SRAS_ADDR_BITS-1:0]       reg_rd_addr,
    input  wire logic [`SRAS_WORD_BITS-1:0]  reg_rdata
);

    if (MAX_ADDR >= (1 << `SRAS_ADDR_BITS)) begin : g_bad_max
        $error("MAX_ADDR exceeds the address field");
    end

    localparam logic [`SRAS_ADDR_BITS-1:0] MAX_PTR = `SRAS_ADDR_BITS'(MAX_ADDR);

    // A start address above the maximum also saturates, so the pointer can never wrap
    function automatic logic at_max(input logic [`SRAS_ADDR_BITS-1:0] ptr);
        return ptr >= MAX_PTR;
    endfunction : at_max

    function automatic logic cmd_enabled(input logic [`SRAS_WORD_BITS-1:0] word);
        return word[`SRAS_EN_MSB:`SRAS_EN_LSB] == `SRAS_EN_PATTERN;
    endfunction : cmd_enabled

    logic [`SRAS_SYNC_BITS-1:0] pins_s;
    logic                       sclk_s;
    logic                       cs_n_s;
    logic                       sdi_s;
    logic                       sclk_q;
    logic                       rise;
    logic                       fall;
    logic                       last_bit;

    sras_pkg::sras_state_t      state;
    logic [`SRAS_CNT_BITS-1:0]  bit_cnt;
    logic [`SRAS_WORD_BITS-1:0] in_shift;
    logic [`SRAS_WORD_BITS-1:0] next_word;
    logic [`SRAS_WORD_BITS-1:0] out_shift;
    logic                       ptr_full;

    // Pins cross into the core clock
    sras_sync #(
        .WIDTH     (`SRAS_SYNC_BITS),
        .RESET_VAL (`SRAS_SYNC_RST)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({spi_sclk, spi_cs_n, spi_sdi}),
        .sync_out (pins_s)
    );

    assign {sclk_s, cs_n_s, sdi_s} = pins_s;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk_s;
        end
    end

    // Edges only count while selected, so sclk idle level is irrelevant
    assign rise      = !cs_n_s && sclk_s && !sclk_q;
    assign fall      = !cs_n_s && !sclk_s && sclk_q;
    assign last_bit  = bit_cnt == `SRAS_CNT_LAST;
    assign next_word = {in_shift[`SRAS_WORD_BITS-2:0], sdi_s};

    // Transaction sequencing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= sras_pkg::SRAS_IDLE;
        end else if (cs_n_s) begin
            state <= sras_pkg::SRAS_IDLE;
        end else begin
            case (state)
                sras_pkg::SRAS_IDLE: begin
                    state <= sras_pkg::SRAS_CMD;
                end
                sras_pkg::SRAS_CMD: begin
                    if (rise && last_bit) begin
                        if (!cmd_enabled(next_word)) begin
                            state <= sras_pkg::SRAS_IGNORE;
                        end else if (next_word[`SRAS_RW_BIT] == `SRAS_RW_READ) begin
                            state <= sras_pkg::SRAS_READ;
                        end else begin
                            state <= sras_pkg::SRAS_WRITE;
                        end
                    end
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    // Bit counter wraps every sixteen rising edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= '0;
        end else if (state == sras_pkg::SRAS_IDLE) begin
            bit_cnt <= '0;
        end else if (rise) begin
            bit_cnt <= `SRAS_CNT_BITS'(bit_cnt + `SRAS_CNT_ONE);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_shift <= '0;
        end else if (rise) begin
            in_shift <= next_word;
        end
    end

    // Address pointer; saturates instead of wrapping
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_addr <= '0;
            ptr_full    <= 1'b0;
        end else if (state == sras_pkg::SRAS_IDLE) begin
            ptr_full    <= 1'b0;
        end else if (rise && last_bit) begin
            case (state)
                sras_pkg::SRAS_CMD: begin
                    reg_rd_addr <= next_word[`SRAS_ADDR_MSB:0];
                end
                sras_pkg::SRAS_WRITE, sras_pkg::SRAS_READ: begin
                    if (at_max(reg_rd_addr)) begin
                        ptr_full <= 1'b1;
                    end else begin
                        reg_rd_addr <= `SRAS_ADDR_BITS'(reg_rd_addr + 1'b1);
                    end
                end
                default: begin
                    reg_rd_addr <= reg_rd_addr;
                end
            endcase
        end
    end

    // Write strobe; words past the maximum are dropped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_wr     <= 1'b0;
            reg_wr_req <= '0;
        end else begin
            reg_wr <= rise && last_bit && state == sras_pkg::SRAS_WRITE
                      && !ptr_full;
            if (rise && last_bit && state == sras_pkg::SRAS_WRITE) begin
                reg_wr_req.addr <= reg_rd_addr;
                reg_wr_req.data <= next_word;
            end
        end
    end

    // Read fetch: one pulse per read word, raised on the same edge that loads the pointer.
    // The pointer is already stable when the pulse is seen.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd <= 1'b0;
        end else if (cs_n_s) begin
            reg_rd <= 1'b0;
        end else begin
            reg_rd <= rise && last_bit
                      && ((state == sras_pkg::SRAS_CMD
                           && cmd_enabled(next_word)
                           && next_word[`SRAS_RW_BIT] == `SRAS_RW_READ)
                          || state == sras_pkg::SRAS_READ);
        end
    end

    // Serial output; released while deselected or not reading
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_shift  <= '0;
            spi_sdo    <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else if (cs_n_s) begin
            spi_sdo    <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end else if (reg_rd) begin
            out_shift  <= reg_rdata;
        end else if (fall && state == sras_pkg::SRAS_READ) begin
            spi_sdo    <= out_shift[`SRAS_WORD_BITS-1];
            spi_sdo_oe <= 1'b1;
            out_shift  <= {out_shift[`SRAS_WORD_BITS-2:0], 1'b0};
        end
    end

endmodule : sras_slave

// ### sim/sras_monitor.sv
`timescale 1ns/1ps
`include "sras_defs.svh"
module sras_monitor #(
    parameter int unsigned MAX_ADDR = `SRAS_ADDR_MAX
) (
    // Clock and reset
    input wire logic                       core_clk,
    input wire logic                       rst_n,
    // Serial pins
    input wire logic                       spi_sclk,
    input wire logic                       spi_cs_n,
    input wire logic                       spi_sdi,
    input wire logic                       spi_sdo,
    input wire logic                       spi_sdo_oe,
    // Register file
    input wire logic                       reg_wr,
    input wire sras_pkg::sras_wr_t         reg_wr_req,
    input wire logic                       reg_rd,
    input wire logic [`SRAS_ADDR_BITS-1:0] reg_rd_addr,
    input wire logic [`SRAS_WORD_BITS-1:0] reg_rdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_oe_deselect: assert property (spi_cs_n [*6] |-> !spi_sdo_oe)
        else $error("sdo enabled while deselected");
    chk_sdo_quiet: assert property (!spi_sdo_oe |-> !spi_sdo)
        else $error("sdo not quiet while released");
    chk_oe_on_fall: assert property ($rose(spi_sdo_oe) |-> !spi_sclk && !$past(spi_sclk, 3))
        else $error("sdo enabled away from a falling sclk");
    chk_sdo_on_fall: assert property (spi_sdo_oe && $past(spi_sdo_oe) && $changed(spi_sdo)
        |-> !$past(spi_sclk, 3))
        else $error("sdo changed away from a falling sclk");
    chk_wr_on_rise: assert property (reg_wr |-> spi_sclk && !$past(spi_cs_n, 6))
        else $error("write not tied to a rising sclk in frame");
    chk_wr_ptr_step: assert property (reg_wr |-> reg_rd_addr == ((reg_wr_req.addr >= MAX_ADDR)
        ? reg_wr_req.addr : reg_wr_req.addr + 10'h1))
        else $error("pointer step after write wrong");
    chk_wr_word_gap: assert property (reg_wr |=> !reg_wr [*8])
        else $error("writes closer than one word");
    chk_rd_bound: assert property (reg_rd |-> reg_rd_addr <= MAX_ADDR)
        else $error("read pointer beyond maximum");
    chk_rd_in_frame: assert property (reg_rd |-> spi_sclk && !$past(spi_cs_n, 6))
        else $error("read fetch outside a rising sclk in frame");
    cover property (reg_wr && reg_wr_req.addr == MAX_ADDR);
    cover property ($rose(spi_sdo_oe));
    cover property (reg_rd && reg_rd_addr == MAX_ADDR);
endmodule : sras_monitor

// ### sim/sras_master.sv
`timescale 1ns/1ps
module sras_master (
    // Clock reference
    input wire logic core_clk,
    // Serial pins
    output logic     spi_sclk,
    output logic     spi_cs_n,
    output logic     spi_sdi,
    input wire logic spi_miso
);
    initial begin
        spi_sclk = 1'h0;
        spi_cs_n = 1'h1;
        spi_sdi  = 1'h0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge core_clk);
    endtask : hold
    // Words MSB first; read words come back left aligned in rd
    task automatic xfer(input logic [15:0] cmd, input int nw, input logic [63:0] wd,
                        input logic idle, output logic [63:0] rd);
        logic [79:0] bits;
        bits = {cmd, wd};
        rd = '0;
        spi_sclk = idle;
        hold(10);
        spi_cs_n = 1'h0;
        hold(5);
        for (int i = 0; i < 16 * (nw + 1); i++) begin
            spi_sclk = 1'h0;
            spi_sdi = bits[79 - i];
            hold(10);
            spi_sclk = 1'h1;
            if (i >= 16) rd = {rd[62:0], spi_miso};
            hold(10);
        end
        rd = rd << (16 * (4 - nw));
        spi_sclk = idle;
        hold(5);
        spi_cs_n = 1'h1;
        spi_sdi = ~spi_sdi;
        hold(10);
    endtask : xfer
endmodule : sras_master

// ### sim/testbench.sv
`timescale 1ns/1ps
`include "sras_defs.svh"
module testbench;
    localparam int unsigned MAX_ADDR = 3;
    logic core_clk = 1'h0, rst_n = 1'h0;
    logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe, spi_miso, reg_wr, reg_rd;
    sras_pkg::sras_wr_t reg_wr_req;
    logic [`SRAS_ADDR_BITS-1:0] reg_rd_addr;
    logic [`SRAS_WORD_BITS-1:0] reg_rdata;
    logic [15:0] mem [0:3] = '{16'h0F0F, 16'h1234, 16'h5678, 16'h9ABC};
    logic [63:0] rd;
    int error_cnt = 0, comparisons = 0, cyc = 0, wr_cnt = 0, oe_cnt = 0;
    always #2 core_clk = ~core_clk;
    // Released sdo reads as the inverse, so a missing drive shows up
    assign spi_miso = spi_sdo_oe ? spi_sdo : ~spi_sdo;
    assign reg_rdata = mem[reg_rd_addr[1:0]];
    sras_slave #(.MAX_ADDR(MAX_ADDR)) DUT (.core_clk(core_clk), .rst_n(rst_n),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe), .reg_wr(reg_wr), .reg_wr_req(reg_wr_req), .reg_rd(reg_rd),
        .reg_rd_addr(reg_rd_addr), .reg_rdata(reg_rdata));
    sras_master u_master (.core_clk(core_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi), .spi_miso(spi_miso));
    task automatic stop_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    always @(posedge core_clk) begin
        if (reg_wr) begin
            mem[reg_wr_req.addr[1:0]] <= reg_wr_req.data;
            wr_cnt++;
        end
        if (spi_sdo_oe) oe_cnt++;
        if (++cyc == 20000) begin
            error_cnt++;
            $display("mismatch at %0t: timeout", $time);
            stop_test();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Four words from address 1 with maximum 3: the last must be dropped
    task automatic t_burst_write();
        u_master.xfer(16'hE001, 4, 64'hA001_B002_C003_D004, 1'h0, rd);
        check(mem[1], 16'hA001);
        check(mem[2], 16'hB002);
        check(mem[3], 16'hC003);
        check(16'(wr_cnt), 16'h0003);
        check(mem[0], 16'h0F0F);
    endtask : t_burst_write
    task automatic t_single_write();
        u_master.xfer(16'hE000, 1, 64'h5AC3_0000_0000_0000, 1'h1, rd);
        check(mem[0], 16'h5AC3);
        check(16'(wr_cnt), 16'h0004);
    endtask : t_single_write
    task automatic t_bad_enable();
        u_master.xfer(16'hF000, 1, 64'h1111_0000_0000_0000, 1'h0, rd);
        u_master.xfer(16'h6402, 1, 64'h0, 1'h0, rd);
        check(mem[0], 16'h5AC3);
        check(16'(wr_cnt), 16'h0004);
        check(16'(oe_cnt), 16'h0000);
    endtask : t_bad_enable
    task automatic t_burst_read();
        u_master.xfer(16'hE402, 3, 64'hFFFF_0000_FFFF_0000, 1'h0, rd);
        check(rd[63:48], 16'hB002);
        check(rd[47:32], 16'hC003);
        check(rd[31:16], 16'hC003);
        check({15'h0, spi_sdo_oe}, 16'h0000);
    endtask : t_burst_read
    initial begin
        repeat (8) @(negedge core_clk);
        rst_n = 1'h1;
        t_burst_write();
        t_single_write();
        t_bad_enable();
        t_burst_read();
        stop_test();
    end
endmodule : testbench
bind sras_slave sras_monitor #(.MAX_ADDR(MAX_ADDR)) u_mon (.core_clk(core_clk), .rst_n(rst_n),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe), .reg_wr(reg_wr), .reg_wr_req(reg_wr_req), .reg_rd(reg_rd),
    .reg_rd_addr(reg_rd_addr), .reg_rdata(reg_rdata));
